// ### core/wdr_cfg.svh
// wdr_cfg.svh: constants of the watchdog reset timer
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH
`define WDR_CLK_HZ      250000000
`define WDR_OSC_HZ      10240
`define WDR_OSC_DIV     (`WDR_CLK_HZ / `WDR_OSC_HZ)
`define WDR_NORM_EXT    15'h0400
`define WDR_LONG_EXT    15'h1000
`define WDR_RST_EXT     15'h0800
`define WDR_INT_SHORT_MS 100
`define WDR_INT_LONG_MS  1600
`define WDR_INT_RST_MS   200
`define WDR_MS_TICKS(ms) (15'((ms) * `WDR_OSC_HZ / 1000))
`define WDR_CTRL_OFS    4'h0
`define WDR_STAT_OFS    4'h4
`define WDR_ISTS_OFS    4'h8
`define WDR_IMSK_OFS    4'hC
`define WDR_CTRL_RST    1'b1
`define WDR_IMSK_RST    3'h0
`define WDR_IRQ_EXP     0
`define WDR_IRQ_REL     1
`define WDR_IRQ_KICK    2
`define WDR_ST_CNT_LSB  8
`define WDR_PIN_W       8
`endif

// ### core/wdr_pkg.sv
// wdr_pkg.sv: types of the watchdog reset timer
`default_nettype none
package wdr_pkg;
  typedef enum logic [3:0] {
    WDR_IDLE = 4'h1,
    WDR_LONG = 4'h2,
    WDR_NORM = 4'h4,
    WDR_RST  = 4'h8
  } wdr_state_t;

  typedef struct packed {
    wdr_state_t  state;
    logic [14:0] cnt;
    logic [14:0] div;
    logic        flag_n;
    logic        rst_n;
    logic        kick_prev;
    logic        tb_prev;
    logic        ack;
    logic [31:0] rdata;
    logic        en;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_msk;
  } wdr_regs_t;
endpackage : wdr_pkg
`default_nettype wire

// ### core/wdr_sync.sv
// wdr_sync.sv: two-flop synchronisers for the pin inputs
`default_nettype none
module wdr_sync #(
  parameter int W = 8
) (
  input  wire logic         i_ref_clk, // system clock
  input  wire logic [W-1:0] i_pins,    // asynchronous pins
  output logic      [W-1:0] o_sync     // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // one two-stage chain per pin; no reset, so the chain already holds the
  // pin level when the block leaves reset and no false edge follows it
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_ref_clk) begin
        meta_r[g] <= i_pins[g];
        sync_r[g] <= meta_r[g];
      end
    end
  endgenerate

  assign o_sync = sync_r;
endmodule : wdr_sync
`default_nettype wire

// ### core/wdr_top.sv
// wdr_top.sv: watchdog reset timer with avalon-mm registers
// Contract
// - missed kick drives reset low, 200 ms
// - long timeout applies right after reset
// - first kick after reset selects normal period
// - timeout count restarts when reset releases
// - kick edge either way clears the counter outside reset
// - stuck kick repeats reset pulses periodically
// - floating kick input disables the watchdog
// - power fail disables the watchdog timer
// - expiry drops flag until next kick
// - power fail forces flag output high
// - external clock counts 1024/4096/2048 clocks
// - select high or floating uses internal oscillator
// - oscillator input level picks normal period
// - internal timebase runs at 10.24 kHz
// - fixed variant uses long timeout always
`include "wdr_cfg.svh"
`default_nettype none
module wdr_top #(
  parameter int OSC_DIV = `WDR_OSC_DIV
) (
  input  wire logic        i_ref_clk,                // 250 MHz clock
  input  wire logic        i_srst,                   // sync reset, high
  input  wire logic        i_watchdog_kick_input,    // kick pin level
  input  wire logic        i_kick_float,             // kick pin floating
  input  wire logic        i_timebase_source_select, // source select pin
  input  wire logic        i_select_float,           // select pin floating
  input  wire logic        i_timebase_input,         // ext clock or level
  input  wire logic        i_timebase_float,         // timebase pin floating
  input  wire logic        i_power_fail,             // supply fail condition
  input  wire logic        i_fixed_variant,          // strap: no select pins
  input  wire logic [3:0]  i_avs_address,            // byte address
  input  wire logic        i_avs_read,               // read request
  input  wire logic        i_avs_write,              // write request
  input  wire logic [31:0] i_avs_writedata,          // write data
  input  wire logic [3:0]  i_avs_byteenable,         // byte lanes
  output logic      [31:0] o_avs_readdata,           // read data
  output logic             o_avs_waitrequest,        // stall
  output logic             o_reset_n,                // reset out, low
  output logic             o_timeout_flag_output_n,  // timeout flag, low
  output logic             o_irq                     // interrupt level
);
  wdr_pkg::wdr_regs_t s;
  wdr_pkg::wdr_regs_t n;

  logic [`WDR_PIN_W-1:0] pins;
  logic [`WDR_PIN_W-1:0] pin_s;
  logic        kick_s;
  logic        kick_flt_s;
  logic        ext_mode;
  logic        osc_hi;
  logic        fixed_s;
  logic        tb_s;
  logic        pf_s;
  logic        en;
  logic        kick_edge;
  logic        int_tick;
  logic        tick;
  logic [14:0] lim;
  logic        expire;
  logic        bus_req;
  logic [2:0]  ev;
  logic [31:0] rd_mux;

  // limit of the count for the state and timebase configuration
  function automatic logic [14:0] wdr_limit(input wdr_pkg::wdr_state_t st,
                                            input logic ext,
                                            input logic ohi,
                                            input logic fix);
    logic [14:0] v;
    v = `WDR_MS_TICKS(`WDR_INT_LONG_MS);
    if (st == wdr_pkg::WDR_RST) begin
      v = ext ? `WDR_RST_EXT : `WDR_MS_TICKS(`WDR_INT_RST_MS);
    end else if (ext) begin
      v = (st == wdr_pkg::WDR_NORM) ? `WDR_NORM_EXT : `WDR_LONG_EXT;
    end else if (st == wdr_pkg::WDR_NORM && !fix && !ohi) begin
      v = `WDR_MS_TICKS(`WDR_INT_SHORT_MS);
    end
    return v;
  endfunction : wdr_limit

  // pin inputs pass through two flops
  assign pins = {i_fixed_variant, i_power_fail, i_timebase_float, i_timebase_input,
                 i_select_float, i_timebase_source_select, i_kick_float,
                 i_watchdog_kick_input};

  wdr_sync #(
    .W (`WDR_PIN_W)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_pins    (pins),
    .o_sync    (pin_s)
  );

  // pin decode; floating groups with high where the table does
  assign kick_s     = pin_s[0];
  assign kick_flt_s = pin_s[1];
  assign fixed_s    = pin_s[7];
  assign ext_mode   = !fixed_s && !(pin_s[2] || pin_s[3]);
  assign tb_s       = pin_s[4];
  assign osc_hi     = pin_s[4] || pin_s[5];
  assign pf_s       = pin_s[6];

  // watchdog runs only when enabled, powered and kick pin driven; the idle
  // cycle only loads the pin history, so a level held over reset is no kick
  assign en        = s.en && !pf_s && !kick_flt_s;
  assign kick_edge = en && (s.state != wdr_pkg::WDR_IDLE)
                     && (kick_s != s.kick_prev);

  // timebase tick: internal divider or rising edge of external clock
  assign int_tick = !ext_mode && (s.div == 15'(OSC_DIV - 1));
  assign tick     = ext_mode ? (tb_s && !s.tb_prev) : int_tick;
  assign lim      = wdr_limit(s.state, ext_mode, osc_hi, fixed_s);
  assign expire   = tick && (s.cnt == lim - 15'h0001);

  // bus handshake and read mux
  assign bus_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = bus_req && !s.ack;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_avs_address == `WDR_CTRL_OFS) begin
      rd_mux[0] = s.en;
    end else if (i_avs_address == `WDR_STAT_OFS) begin
      rd_mux[0]     = s.rst_n;
      rd_mux[1]     = s.flag_n;
      rd_mux[2]     = en;
      rd_mux[3]     = ext_mode;
      rd_mux[7:4]   = s.state;
      rd_mux[22:8]  = s.cnt;
    end else if (i_avs_address == `WDR_ISTS_OFS) begin
      rd_mux[2:0] = s.irq_sts;
    end else if (i_avs_address == `WDR_IMSK_OFS) begin
      rd_mux[2:0] = s.irq_msk;
    end
  end

  // next state of the whole block
  always_comb begin
    n           = s;
    ev          = 3'h0;
    n.kick_prev = kick_s;
    n.tb_prev   = tb_s;
    n.ack       = bus_req && !s.ack;
    // internal divider, held cleared when disabled or external
    if (ext_mode || !en || int_tick) begin
      n.div = 15'h0000;
    end else begin
      n.div = s.div + 15'h0001;
    end
    if (kick_edge) begin
      n.flag_n = 1'b1;
      ev[`WDR_IRQ_KICK] = 1'b1;
    end
    if (!en) begin
      n.state = wdr_pkg::WDR_IDLE;
      n.cnt   = 15'h0000;
      n.rst_n = 1'b1;
    end else begin
      case (s.state)
        wdr_pkg::WDR_IDLE: begin
          n.state = wdr_pkg::WDR_LONG;
          n.cnt   = 15'h0000;
        end
        wdr_pkg::WDR_LONG, wdr_pkg::WDR_NORM: begin
          if (kick_edge) begin
            n.state = wdr_pkg::WDR_NORM;
            n.cnt   = 15'h0000;
          end else if (expire) begin
            n.state  = wdr_pkg::WDR_RST;
            n.cnt    = 15'h0000;
            n.rst_n  = 1'b0;
            n.flag_n = 1'b0;
            ev[`WDR_IRQ_EXP] = 1'b1;
          end else if (tick) begin
            n.cnt = s.cnt + 15'h0001;
          end
        end
        wdr_pkg::WDR_RST: begin
          if (expire) begin
            n.state = wdr_pkg::WDR_LONG;
            n.cnt   = 15'h0000;
            n.rst_n = 1'b1;
            ev[`WDR_IRQ_REL] = 1'b1;
          end else if (tick) begin
            n.cnt = s.cnt + 15'h0001;
          end
        end
        default: begin
          n.state = wdr_pkg::WDR_IDLE;
          n.cnt   = 15'h0000;
          n.rst_n = 1'b1;
        end
      endcase
    end
    if (pf_s) begin
      n.flag_n = 1'b1;
    end
    // read data captured in the wait cycle, shown at the answer
    if (bus_req && !s.ack) begin
      n.rdata = rd_mux;
    end
    // register writes take effect at the answer edge
    if (i_avs_write && s.ack && i_avs_byteenable[0]) begin
      if (i_avs_address == `WDR_CTRL_OFS) begin
        n.en = i_avs_writedata[0];
      end else if (i_avs_address == `WDR_IMSK_OFS) begin
        n.irq_msk = i_avs_writedata[2:0];
      end
    end
    // sticky events; a read clears only what it returned, set wins
    n.irq_sts = s.irq_sts;
    if (i_avs_read && s.ack && i_avs_address == `WDR_ISTS_OFS) begin
      n.irq_sts = s.irq_sts & ~s.rdata[2:0];
    end
    n.irq_sts = n.irq_sts | ev;
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s.state     <= wdr_pkg::WDR_IDLE;
      s.cnt       <= 15'h0000;
      s.div       <= 15'h0000;
      s.flag_n    <= 1'b1;
      s.rst_n     <= 1'b1;
      s.kick_prev <= 1'b0;
      s.tb_prev   <= 1'b0;
      s.ack       <= 1'b0;
      s.rdata     <= 32'h0000_0000;
      s.en        <= `WDR_CTRL_RST;
      s.irq_sts   <= 3'h0;
      s.irq_msk   <= `WDR_IMSK_RST;
    end else begin
      s <= n;
    end
  end

  // outputs
  assign o_avs_readdata          = s.rdata;
  assign o_reset_n               = s.rst_n;
  assign o_timeout_flag_output_n = s.flag_n;
  assign o_irq                   = |(s.irq_sts & s.irq_msk);

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  reset_entry_a: assert property (
    (en && (s.state == wdr_pkg::WDR_NORM) && expire && !kick_edge)
      |=> (!o_reset_n && !o_timeout_flag_output_n && s.state == wdr_pkg::WDR_RST))
    else $error("missed kick did not start a reset pulse");

  reset_hold_a: assert property (
    (en && s.state == wdr_pkg::WDR_RST && !expire) |=> !o_reset_n)
    else $error("reset released before its count ended");

  long_after_a: assert property (
    (en && $rose(o_reset_n)) |-> (s.state == wdr_pkg::WDR_LONG && s.cnt == 15'h0000))
    else $error("release did not restart the long timeout");

  normal_switch_a: assert property (
    (en && s.state == wdr_pkg::WDR_LONG && kick_edge) ##1 en
      |-> (s.state == wdr_pkg::WDR_NORM))
    else $error("first kick did not select the normal period");

  kick_clear_a: assert property (
    (kick_edge && s.state != wdr_pkg::WDR_RST) |=> (s.cnt == 15'h0000))
    else $error("kick edge did not clear the counter");

  float_off_a: assert property (
    kick_flt_s |=> (s.state == wdr_pkg::WDR_IDLE && o_reset_n && s.cnt == 15'h0000))
    else $error("floating kick left the watchdog running");

  pfail_off_a: assert property (
    pf_s |=> (o_timeout_flag_output_n && o_reset_n && s.cnt == 15'h0000))
    else $error("power fail did not stop the watchdog");

  flag_hold_a: assert property (
    (!o_timeout_flag_output_n && !kick_edge && !pf_s) |=> !o_timeout_flag_output_n)
    else $error("timeout flag rose without a kick");

  ext_limit_a: assert property (
    (en && ext_mode && s.state == wdr_pkg::WDR_RST && tick
      && s.cnt == `WDR_RST_EXT - 15'h0001) |=> o_reset_n)
    else $error("external reset time is not 2048 clocks");

  osc_tick_a: assert property (
    (!ext_mode && en && int_tick) |=> (!int_tick [*2]))
    else $error("internal tick came too often");

  // limits seen from outside: the last tick of the external normal and long and internal short periods
  ext_norm_a: assert property (
    (en && ext_mode && s.state == wdr_pkg::WDR_NORM && tick && !kick_edge
      && s.cnt == `WDR_NORM_EXT - 15'h0001) |=> !o_reset_n)
    else $error("external normal timeout is not 1024 clocks");

  ext_long_a: assert property (
    (en && ext_mode && s.state == wdr_pkg::WDR_LONG && tick && !kick_edge
      && s.cnt == `WDR_LONG_EXT - 15'h0001) |=> !o_reset_n)
    else $error("external long timeout is not 4096 clocks");

  int_short_a: assert property (
    (en && !ext_mode && !osc_hi && !fixed_s && s.state == wdr_pkg::WDR_NORM && tick
      && !kick_edge && s.cnt == `WDR_MS_TICKS(`WDR_INT_SHORT_MS) - 15'h0001)
      |=> !o_reset_n)
    else $error("internal short timeout is not 100 ms");

  // start-up, refused kicks, cleared divider, flag and interrupt
  idle_start_a: assert property (
    (en && s.state == wdr_pkg::WDR_IDLE) |=> (s.state == wdr_pkg::WDR_LONG))
    else $error("enabled watchdog did not enter the long period");

  rst_kick_a: assert property (
    (en && s.state == wdr_pkg::WDR_RST && kick_edge && !expire)
      |=> (s.state == wdr_pkg::WDR_RST && !o_reset_n))
    else $error("kick during reset cut the reset pulse");

  div_clear_a: assert property (
    !en |=> (s.div == 15'h0000))
    else $error("internal divider ran while disabled");

  flag_kick_a: assert property (
    (en && !o_timeout_flag_output_n && kick_edge) |=> o_timeout_flag_output_n)
    else $error("kick did not raise the timeout flag");

  irq_raise_a: assert property (
    ($fell(o_reset_n) && s.irq_msk[`WDR_IRQ_EXP]) |-> o_irq)
    else $error("expiry did not raise the interrupt");

  expiry_cov: cover property (en ##1 $fell(o_reset_n));
  release_cov: cover property ($rose(o_reset_n));
  normal_cov: cover property (s.state == wdr_pkg::WDR_LONG ##1 s.state == wdr_pkg::WDR_NORM);
  irq_cov: cover property ($rose(o_irq));
  intmode_cov: cover property (!ext_mode ##1 $fell(o_reset_n));
endmodule : wdr_top
`default_nettype wire

// ### verification/tb_top.sv
// tb_top.sv: self-checking bench of the watchdog reset timer
`include "wdr_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NORM = 2048; // external clock period is two system clocks
  localparam int LONG = 8192;
  localparam int RSTT = 4096;
  localparam int INT_NORM = 4096; // 1024 internal ticks of four system clocks
  localparam int INT_RST = 8192;
  logic        clk = 1'b0;
  logic        srst, kick, kflt, pf, ext, run, once, rd_r, wr_r, sel, ext_on;
  logic [3:0]  addr, be;
  logic [31:0] wd, rdata, rd;
  logic        wait_r, rst_n, flag_n, irq;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t, lows;
  wdr_host_model host (.i_ref_clk(clk), .i_run(run), .i_once(once), .i_gap(16'h05DC),
    .o_kick(kick));
  wdr_top #(.OSC_DIV(4)) uut (.i_ref_clk(clk), .i_srst(srst), .i_watchdog_kick_input(kick),
    .i_kick_float(kflt), .i_timebase_source_select(sel), .i_select_float(1'b0),
    .i_timebase_input(ext), .i_timebase_float(1'b0), .i_power_fail(pf),
    .i_fixed_variant(1'b0), .i_avs_address(addr), .i_avs_read(rd_r), .i_avs_write(wr_r),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .o_reset_n(rst_n), .o_timeout_flag_output_n(flag_n),
    .o_irq(irq));
  // system clock, free cycle count and external timebase
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ext <= ext_on ? ~ext : 1'b0; // held low as a level in internal mode
  end
  task automatic complete_run();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic check_near(input string what, input int exp, input int got);
    n_compared++;
    if (got < exp - 8 || got > exp + 8) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_near
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    rd_r <= ~w;
    wr_r <= w;
    addr <= a;
    wd   <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    r = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    if (n >= 50) begin
      failures++;
      complete_run();
    end
  endtask : bus
  task automatic wait_rst(input logic v, input int bound);
    int n;
    n = 0;
    while (rst_n !== v) begin
      @(posedge clk);
      n++;
      if (n > bound) begin
        failures++;
        complete_run();
      end
    end
  endtask : wait_rst
  task automatic count_low(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      if (rst_n !== 1'b1) n++;
    end
  endtask : count_low
  task automatic pulse_srst();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask : pulse_srst
  // main sequence
  initial begin
    {srst, kflt, pf, ext, run, once, rd_r, wr_r} = 8'h80;
    addr = 4'h0;
    wd = 32'h0;
    sel = 1'b0;
    ext_on = 1'b1;
    be = 4'hF;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t = cyc;
    bus(1'b0, `WDR_CTRL_OFS, 32'h0, rd);
    check("ctrl reset", 32'h1, rd);
    bus(1'b0, 4'h2, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    bus(1'b1, `WDR_IMSK_OFS, 32'h1, rd);
    bus(1'b0, `WDR_IMSK_OFS, 32'h0, rd);
    check("mask", 32'h1, rd);
    be <= 4'h0;
    bus(1'b1, `WDR_IMSK_OFS, 32'h0, rd);
    be <= 4'hF;
    bus(1'b0, `WDR_IMSK_OFS, 32'h0, rd);
    check("lane off", 32'h1, rd);
    check("irq idle", 32'h0, 32'(irq));
    $display("registers done");
    wait_rst(1'b0, LONG + 50);
    check_near("first timeout", LONG, cyc - t);
    t = cyc;
    repeat (4) @(posedge clk);
    check("flag low", 32'h0, 32'(flag_n));
    check("irq up", 32'h1, 32'(irq));
    bus(1'b0, `WDR_ISTS_OFS, 32'h0, rd);
    check("irq status", 32'h1, rd & 32'h1);
    @(posedge clk);
    check("irq cleared", 32'h0, 32'(irq));
    wait_rst(1'b1, RSTT + 50);
    check_near("reset time", RSTT, cyc - t);
    t = cyc;
    wait_rst(1'b0, LONG + 50);
    check_near("stuck kick", LONG, cyc - t);
    $display("long period done");
    wait_rst(1'b1, RSTT + 50);
    once <= 1'b1;
    @(posedge clk);
    once <= 1'b0;
    t = cyc;
    repeat (5) @(posedge clk);
    check("flag after kick", 32'h1, 32'(flag_n));
    wait_rst(1'b0, NORM + 50);
    check_near("normal timeout", NORM, cyc - t);
    $display("normal period done");
    pf <= 1'b1;
    repeat (5) @(posedge clk);
    check("flag power fail", 32'h1, 32'(flag_n));
    count_low(LONG + 200, lows);
    check("power fail", 32'h0, 32'(lows));
    pf <= 1'b0;
    pulse_srst();
    kflt <= 1'b1;
    repeat (5) @(posedge clk);
    count_low(LONG + 200, lows);
    check("floating kick", 32'h0, 32'(lows));
    kflt <= 1'b0;
    $display("disable done");
    pulse_srst();
    run <= 1'b1;
    count_low(6 * NORM, lows);
    check("kept alive", 32'h0, 32'(lows));
    run <= 1'b0;
    sel <= 1'b1;
    ext_on <= 1'b0;
    $display("keep alive done");
    pulse_srst();
    repeat (4) @(posedge clk);
    bus(1'b0, `WDR_STAT_OFS, 32'h0, rd);
    check("internal long", 32'h20, rd & 32'hF8);
    once <= 1'b1;
    @(posedge clk);
    once <= 1'b0;
    t = cyc;
    wait_rst(1'b0, INT_NORM + 50);
    check_near("internal normal", INT_NORM, cyc - t);
    t = cyc;
    repeat (8) @(posedge clk);
    once <= 1'b1;
    @(posedge clk);
    once <= 1'b0;
    repeat (5) @(posedge clk);
    check("flag in reset", 32'h1, 32'(flag_n));
    check("reset held", 32'h0, 32'(rst_n));
    wait_rst(1'b1, INT_RST + 50);
    check_near("internal reset", INT_RST, cyc - t);
    $display("internal timebase done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// ### verification/wdr_host_model.sv
// wdr_host_model.sv: host processor model that toggles the kick pin
`default_nettype none
module wdr_host_model (
  input  wire logic        i_ref_clk, // system clock
  input  wire logic        i_run,     // periodic kicking on
  input  wire logic        i_once,    // single kick request
  input  wire logic [15:0] i_gap,     // cycles between kicks
  output logic             o_kick     // kick pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial o_kick = 1'b0;
  // toggle on request or when the gap runs out; the level holds in between
  always @(posedge i_ref_clk) begin
    cnt <= (i_run && cnt < int'(i_gap) - 1) ? cnt + 1 : 0;
    if (i_once || (i_run && cnt == int'(i_gap) - 1)) begin
      o_kick <= ~o_kick;
    end
  end
endmodule : wdr_host_model
`default_nettype wire
